/* design/rpa_defines.svh */
// constants for the resonator pitch allocator
//
// Behaviour
// - round robin sends assignment to next active voice
// - after highest active voice, pointer returns to voice 1
// - 128 pitch values; each change is one assignment
// - unassigned voice stays silent
// - concert A adjustable 430.0 to 450.0 Hz, 0.1 steps
// - active count 0..6 limits round robin voices
// - interval mode: only voices 1..N sound
// - count zero clears all stored pitches
// - unison switch sends assignment to all active voices
// - interval mode sets each voice to offset pitch
// - key picks one of twelve tonic classes
// - scale picks major or harmonic step pattern
// - root 1..7 rotates pattern into a mode
// - round rules move out-of-key input one semitone, or two across a three-semitone gap
// - shift rules round, compute, then shift result back
// - unison and octave intervals track raw input
// - per-voice interval has 81 settings
// - master resonance scales feedback 0..100 percent
// - master high cut scales cutoffs 0..100 percent
// - feedback amount is a signed value
// - each voice has its own cutoff setting
`ifndef RPA_DEFINES_SVH
`define RPA_DEFINES_SVH

`define RPA_VOICES        6
`define RPA_PITCH_MAX     7'h7f
`define RPA_INTERVAL_MID  40
`define RPA_INTERVAL_MAX  7'h50
`define RPA_TUNE_BASE     13'h10cc
`define RPA_TUNE_STEPS    8'hc8
`define RPA_PERCENT_FULL  7'h64
`define RPA_KEYS          12
`define RPA_DEGREES       7
`define RPA_MAJOR_STEPS   28'h2212221
`define RPA_HARMON_STEPS  28'h2122131

`endif

/* design/rpa_pkg.sv */
// types shared by the resonator pitch allocator
`include "rpa_defines.svh"
package rpa_pkg;

  typedef enum logic [1:0] {
    RPA_ROUND_DOWN = 2'h0,
    RPA_ROUND_UP   = 2'h1,
    RPA_SHIFT_DOWN = 2'h2,
    RPA_SHIFT_UP   = 2'h3
  } rpa_oor_type;

  typedef logic [`RPA_DEGREES-1:0][3:0] rpa_degree_type;

endpackage : rpa_pkg

/* design/resonator_pitch_allocator.sv */
// pitch allocation, interval harmonizer and master scaling for six resonators
`timescale 1ns/1ps
`include "rpa_defines.svh"

module resonator_pitch_allocator
  import rpa_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      interval_harmonizer_mode,
  input  wire logic [6:0]                pitchAssign,
  input  wire logic [7:0]                tuningStep,
  input  wire logic [2:0]                activeCount,
  input  wire logic                      unisonOn,
  input  wire logic [3:0]                keySel,
  input  wire logic                      scaleHarmonic,
  input  wire logic [2:0]                rootSel,
  input  wire logic [1:0]                outOfKeyRule,
  input  wire logic [5:0][6:0]           per_voice_interval,
  input  wire logic [6:0]                masterResonance,
  input  wire logic [6:0]                master_cutoff_scale,
  input  wire logic signed [5:0][7:0]    voice_feedback_amount,
  input  wire logic [5:0][7:0]           voice_lowpass_cutoff,
  output logic [5:0][6:0]                voicePitch,
  output logic [5:0]                     voiceSounding,
  output logic [12:0]                    refFreqTenths,
  output logic signed [5:0][7:0]         feedbackScaled,
  output logic [5:0][7:0]                cutoffScaled
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cumulative semitone offsets of the mode that starts at the root degree
  function automatic rpa_degree_type modeTable(input logic harm, input logic [2:0] root);
    logic [27:0]    steps;
    rpa_degree_type tab;
    int             r;
    int             acc;
    steps = harm ? `RPA_HARMON_STEPS : `RPA_MAJOR_STEPS;
    r     = (root == 3'h0) ? 0 : int'(root) - 1;
    if (r > 6) r = 6;
    acc   = 0;
    for (int i = 0; i < `RPA_DEGREES; i++) begin
      tab[i] = 4'(acc);
      acc    = acc + int'(steps[4*(6-((r+i)%7)) +: 4]);
    end
    return tab;
  endfunction : modeTable

  function automatic int pitchClass(input int p, input int key);
    return (((p - key) % `RPA_KEYS) + `RPA_KEYS) % `RPA_KEYS;
  endfunction : pitchClass

  function automatic int degreeOf(input int pc, input rpa_degree_type tab);
    int j;
    j = -1;
    for (int i = 0; i < `RPA_DEGREES; i++) begin
      if (int'(tab[i]) == pc) j = i;
    end
    return j;
  endfunction : degreeOf

  function automatic logic [6:0] harmonize(input logic [6:0] p, input logic [6:0] code,
                                           input int key, input rpa_degree_type tab,
                                           input rpa_oor_type rule);
    int d;
    int pi;
    int dir;
    int shift;
    int j;
    int tot;
    int res;
    d     = int'(code) - `RPA_INTERVAL_MID;
    pi    = int'(p);
    shift = 0;
    dir   = 0;
    if (d % `RPA_DEGREES == 0) begin
      res = pi + 12 * (d / `RPA_DEGREES);
    end else begin
      if (degreeOf(pitchClass(pi, key), tab) < 0) begin
        unique case (rule)
          RPA_ROUND_DOWN: dir = -1;
          RPA_ROUND_UP:   dir = 1;
          RPA_SHIFT_DOWN: begin
            dir   = 1;
            shift = -1;
          end
          RPA_SHIFT_UP: begin
            dir   = -1;
            shift = 1;
          end
        endcase
        // a three-semitone gap leaves two foreign notes, so look one further
        pi = pi + dir;
        if (degreeOf(pitchClass(pi, key), tab) < 0) pi = pi + dir;
      end
      j = degreeOf(pitchClass(pi, key), tab);
      if (j < 0) j = 0;
      tot = j + d + 42;
      res = pi - int'(tab[j]) + int'(tab[tot % 7]) + 12 * (tot / 7 - 6) + shift;
    end
    if (res < 0) res = 0;
    if (res > 127) res = 127;
    return 7'(res);
  endfunction : harmonize

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  logic [2:0]     activeClamp;
  logic [5:0]     activeMask;
  logic           assignEvent;
  logic [2:0]     rrBase;
  logic [2:0]     rrTarget;
  rpa_degree_type curTable;
  int             keyInt;

  always_comb begin
    activeClamp = (activeCount > 3'h6) ? 3'h6 : activeCount;
    for (int v = 0; v < `RPA_VOICES; v++) begin
      activeMask[v] = (3'(v) < activeClamp);
    end
    keyInt   = int'(keySel) % `RPA_KEYS;
    curTable = modeTable(scaleHarmonic, rootSel);
  end

  // ----------------------------------------------------------------
  // allocation state
  // ----------------------------------------------------------------
  logic [6:0]      prevAssign_reg;
  logic [6:0]      prevAssign_next;
  logic [2:0]      rrPtr_reg;
  logic [2:0]      rrPtr_next;
  logic [5:0][6:0] voicePitch_reg;
  logic [5:0][6:0] voicePitch_next;
  logic [5:0]      voiceAssigned_reg;
  logic [5:0]      voiceAssigned_next;

  // reset value of the previous sample is 0, so a first value of 0 is no event
  assign assignEvent = (pitchAssign != prevAssign_reg);
  assign rrBase      = (rrPtr_reg < activeClamp) ? rrPtr_reg : 3'h0;
  assign rrTarget    = rrBase;

  always_comb begin
    prevAssign_next    = pitchAssign;
    rrPtr_next         = rrPtr_reg;
    voicePitch_next    = voicePitch_reg;
    voiceAssigned_next = voiceAssigned_reg;
    if (activeClamp == 3'h0) begin
      // muting forgets every pitch so raising the count brings back silence
      voicePitch_next    = '0;
      voiceAssigned_next = '0;
      rrPtr_next         = 3'h0;
    end else if (assignEvent) begin
      if (interval_harmonizer_mode) begin
        for (int v = 0; v < `RPA_VOICES; v++) begin
          voicePitch_next[v] = harmonize(pitchAssign, per_voice_interval[v], keyInt,
                                         curTable, rpa_oor_type'(outOfKeyRule));
        end
        voiceAssigned_next = '1;
      end else if (unisonOn) begin
        for (int v = 0; v < `RPA_VOICES; v++) begin
          if (activeMask[v]) begin
            voicePitch_next[v]    = pitchAssign;
            voiceAssigned_next[v] = 1'b1;
          end
        end
      end else begin
        voicePitch_next[rrTarget]    = pitchAssign;
        voiceAssigned_next[rrTarget] = 1'b1;
        rrPtr_next = (rrTarget + 3'h1 >= activeClamp) ? 3'h0 : rrTarget + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prevAssign_reg    <= 7'h00;
      rrPtr_reg         <= 3'h0;
      voicePitch_reg    <= '0;
      voiceAssigned_reg <= 6'h00;
    end else begin
      prevAssign_reg    <= prevAssign_next;
      rrPtr_reg         <= rrPtr_next;
      voicePitch_reg    <= voicePitch_next;
      voiceAssigned_reg <= voiceAssigned_next;
    end
  end

  assign voicePitch    = voicePitch_reg;
  // a voice sounds only once it holds a pitch and lies inside the count
  assign voiceSounding = voiceAssigned_reg & activeMask;

  // ----------------------------------------------------------------
  // tuning and master scaling
  // ----------------------------------------------------------------
  logic [12:0]            refFreq_reg;
  logic [12:0]            refFreq_next;
  logic signed [5:0][7:0] feedback_reg;
  logic signed [5:0][7:0] feedback_next;
  logic [5:0][7:0]        cutoff_reg;
  logic [5:0][7:0]        cutoff_next;
  int                     resPct;
  int                     cutPct;

  always_comb begin
    refFreq_next = `RPA_TUNE_BASE + 13'((tuningStep > `RPA_TUNE_STEPS)
                                        ? `RPA_TUNE_STEPS : tuningStep);
    // settings above full scale are held at full scale rather than wrapping
    resPct = int'((masterResonance > `RPA_PERCENT_FULL) ? `RPA_PERCENT_FULL : masterResonance);
    cutPct = int'((master_cutoff_scale > `RPA_PERCENT_FULL)
                  ? `RPA_PERCENT_FULL : master_cutoff_scale);
    for (int v = 0; v < `RPA_VOICES; v++) begin
      feedback_next[v] = 8'((int'($signed(voice_feedback_amount[v])) * resPct)
                            / int'(`RPA_PERCENT_FULL));
      cutoff_next[v]   = 8'((int'(voice_lowpass_cutoff[v]) * cutPct)
                            / int'(`RPA_PERCENT_FULL));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      refFreq_reg  <= `RPA_TUNE_BASE;
      feedback_reg <= '0;
      cutoff_reg   <= '0;
    end else begin
      refFreq_reg  <= refFreq_next;
      feedback_reg <= feedback_next;
      cutoff_reg   <= cutoff_next;
    end
  end

  assign refFreqTenths  = refFreq_reg;
  assign feedbackScaled = feedback_reg;
  assign cutoffScaled   = cutoff_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_rr_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (assignEvent && !interval_harmonizer_mode && !unisonOn && activeClamp != 3'h0)
    |=> voicePitch_reg[$past(rrTarget)] == $past(pitchAssign))
    else $error("round robin did not load the target voice");

  chk_rr_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (assignEvent && !interval_harmonizer_mode && !unisonOn && activeClamp != 3'h0
     && rrTarget == activeClamp - 3'h1) |=> rrPtr_reg == 3'h0)
    else $error("round robin pointer failed to wrap");

  chk_no_change: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!assignEvent && activeClamp != 3'h0) |=> $stable(voicePitch_reg))
    else $error("pitch moved without a new assignment");

  chk_silent_unassigned: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((voiceSounding & ~$past(voiceSounding)) != 6'h00)
    |-> ($past(assignEvent) || (activeClamp > $past(activeClamp) && $past(activeClamp) != 3'h0)))
    else $error("unassigned voice is sounding");

  chk_tuning_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (refFreqTenths >= 13'h10cc && refFreqTenths <= 13'h1194))
    else $error("reference tuning out of range");

  chk_active_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (voiceSounding >> ((activeCount > 3'h6) ? 3'h6 : activeCount)) == 6'h00)
    else $error("voice above active count is sounding");

  chk_mute_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (activeCount == 3'h0) ##1 (activeCount != 3'h0 && !assignEvent)
    |-> voiceAssigned_reg == 6'h00 ##1 voiceAssigned_reg == 6'h00)
    else $error("mute did not clear stored pitches");

  chk_unison_all: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (assignEvent && !interval_harmonizer_mode && unisonOn && activeClamp == 3'h6)
    |=> voicePitch_reg[0] == $past(pitchAssign) && voicePitch_reg[5] == $past(pitchAssign))
    else $error("unison did not reach every active voice");

  chk_unison_track: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (assignEvent && interval_harmonizer_mode && activeClamp != 3'h0
     && per_voice_interval[0] == 7'h28) |=> voicePitch_reg[0] == $past(pitchAssign))
    else $error("unison interval did not follow input");

  chk_master_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (masterResonance == 7'h00) [*2] |-> feedbackScaled == '0)
    else $error("zero master resonance left feedback");

  chk_mute_pitch: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (activeCount == 3'h0) |=> voicePitch_reg == '0)
    else $error("mute left a stored pitch");

  chk_clamp_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (assignEvent && interval_harmonizer_mode && activeCount != 3'h0
     && per_voice_interval[3] == 7'h2f && pitchAssign > 7'h73) |=> voicePitch_reg[3] == 7'h7f)
    else $error("octave result above the top pitch was not clamped");

  chk_fb_sign: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (masterResonance == 7'h32 && voice_feedback_amount[0][7]
     && voice_feedback_amount[0] != 8'hff) |=> feedbackScaled[0][7])
    else $error("negative feedback lost its sign");

  chk_cut_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (master_cutoff_scale >= 7'h64) |=> cutoffScaled == $past(voice_lowpass_cutoff))
    else $error("full master cutoff altered a voice cutoff");

endmodule : resonator_pitch_allocator

/* sim/rpa_mod_source.sv */
// modulation source model that drives pitch assign and voice count
`timescale 1ns/1ps

module rpa_mod_source (
  input  wire logic       clk_sys,
  output logic      [6:0] pitchAssign,
  output logic      [2:0] activeCount
);
  initial begin
    pitchAssign = 7'h00;
    activeCount = 3'h0;
  end

  // a repeated value is no new assignment, so callers must change it
  task automatic send_pitch(input logic [6:0] p);
    @(negedge clk_sys);
    pitchAssign = p;
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask : send_pitch

  task automatic set_count(input logic [2:0] n);
    @(negedge clk_sys);
    activeCount = n;
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask : set_count
endmodule : rpa_mod_source

/* sim/tb_top.sv */
// self-checking testbench for the resonator pitch allocator
`timescale 1ns/1ps

module tb_top
  import rpa_pkg::*;
;
  logic                     clk_sys, sys_rst, harmMode, unisonOn, scaleHarmonic;
  logic               [6:0] pitchAssign, masterResonance, masterCut;
  logic               [2:0] activeCount, rootSel;
  logic               [7:0] tuningStep;
  logic               [3:0] keySel;
  logic               [1:0] outOfKeyRule;
  logic          [5:0][6:0] intervals, voicePitch;
  logic signed   [5:0][7:0] fbAmount, feedbackScaled;
  logic          [5:0][7:0] cutAmount, cutoffScaled;
  logic               [5:0] voiceSounding;
  logic              [12:0] refFreqTenths;
  int                       badCount, comparisons;
  logic [3:0][6:0] expV1 = {7'h35, 7'h34, 7'h35, 7'h34};
  logic [3:0][6:0] expV2 = {7'h38, 7'h38, 7'h39, 7'h37};

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  rpa_mod_source SRC (.clk_sys(clk_sys), .pitchAssign(pitchAssign), .activeCount(activeCount));

  resonator_pitch_allocator DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .interval_harmonizer_mode(harmMode),
    .pitchAssign(pitchAssign), .tuningStep(tuningStep), .activeCount(activeCount),
    .unisonOn(unisonOn), .keySel(keySel), .scaleHarmonic(scaleHarmonic), .rootSel(rootSel),
    .outOfKeyRule(outOfKeyRule), .per_voice_interval(intervals),
    .masterResonance(masterResonance), .master_cutoff_scale(masterCut),
    .voice_feedback_amount(fbAmount), .voice_lowpass_cutoff(cutAmount),
    .voicePitch(voicePitch), .voiceSounding(voiceSounding), .refFreqTenths(refFreqTenths),
    .feedbackScaled(feedbackScaled), .cutoffScaled(cutoffScaled));

  // ----------------------------------------
  // compare, wait and closing tasks
  // ----------------------------------------
  task automatic chkPitch(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %0t pitch got %0d exp %0d", $time, got, exp);
    end
  endtask : chkPitch

  task automatic chkMask(input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %0t sounding got %0h exp %0h", $time, got, exp);
    end
  endtask : chkMask

  task automatic chkVal(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %0t value got %0h exp %0h", $time, got, exp);
    end
  endtask : chkVal

  task automatic chkVoices(input logic [5:0][6:0] e);
    for (int i = 0; i < 6; i++) chkPitch(voicePitch[i], e[i]);
  endtask : chkVoices

  task automatic chkBytes(input logic [5:0][7:0] got, input logic [5:0][7:0] exp);
    for (int i = 0; i < 6; i++) chkVal({5'h0, got[i]}, {5'h0, exp[i]});
  endtask : chkBytes

  task automatic step2;
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask : step2

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {harmMode, unisonOn, scaleHarmonic, keySel, outOfKeyRule, tuningStep} = '0;
    {fbAmount, cutAmount} = '0;
    sys_rst = 1'b1;
    rootSel = 3'h0;
    masterResonance = 7'h64;
    masterCut = 7'h64;
    intervals = {7'h28, 7'h28, 7'h2f, 7'h2c, 7'h2a, 7'h28};
    step2();
    sys_rst = 1'b0;
    SRC.set_count(3'h6);
    chkMask(voiceSounding, 6'h00);
    SRC.send_pitch(7'h2d);
    SRC.send_pitch(7'h2f);
    SRC.send_pitch(7'h32);
    SRC.send_pitch(7'h34);
    SRC.send_pitch(7'h36);
    SRC.send_pitch(7'h38);
    chkVoices({7'h38, 7'h36, 7'h34, 7'h32, 7'h2f, 7'h2d});
    SRC.send_pitch(7'h1e);
    chkVoices({7'h38, 7'h36, 7'h34, 7'h32, 7'h2f, 7'h1e});
    chkMask(voiceSounding, 6'h3f);
    $display("test round robin done");
    SRC.set_count(3'h0);
    chkVoices('0);
    SRC.set_count(3'h2);
    chkMask(voiceSounding, 6'h00);
    SRC.send_pitch(7'h3c);
    SRC.send_pitch(7'h3e);
    SRC.send_pitch(7'h40);
    chkVoices({28'h0, 7'h3e, 7'h40});
    chkMask(voiceSounding, 6'h03);
    $display("test active count done");
    SRC.set_count(3'h0);
    SRC.set_count(3'h3);
    unisonOn = 1'b1;
    SRC.send_pitch(7'h46);
    chkVoices({21'h0, 7'h46, 7'h46, 7'h46});
    SRC.set_count(3'h7);
    SRC.send_pitch(7'h47);
    chkVoices({6{7'h47}});
    chkMask(voiceSounding, 6'h3f);
    SRC.set_count(3'h3);
    unisonOn = 1'b0;
    $display("test unison done");
    harmMode = 1'b1;
    SRC.send_pitch(7'h30);
    chkVoices({7'h30, 7'h30, 7'h3c, 7'h37, 7'h34, 7'h30});
    chkMask(voiceSounding, 6'h07);
    for (int r = 0; r < 4; r++) begin
      outOfKeyRule = rpa_oor_type'(r);
      SRC.send_pitch(7'h30);
      SRC.send_pitch(7'h31);
      chkPitch(voicePitch[0], 7'h31);
      chkPitch(voicePitch[3], 7'h3d);
      chkPitch(voicePitch[1], expV1[r]);
      chkPitch(voicePitch[2], expV2[r]);
    end
    outOfKeyRule = 2'h0;
    keySel = 4'h2;
    SRC.send_pitch(7'h32);
    chkPitch(voicePitch[1], 7'h36);
    keySel = 4'he;
    SRC.send_pitch(7'h26);
    chkPitch(voicePitch[1], 7'h2a);
    keySel = 4'h0;
    scaleHarmonic = 1'b1;
    SRC.send_pitch(7'h30);
    chkPitch(voicePitch[1], 7'h33);
    chkPitch(voicePitch[2], 7'h37);
    scaleHarmonic = 1'b0;
    rootSel = 3'h6;
    SRC.send_pitch(7'h01);
    SRC.send_pitch(7'h30);
    chkPitch(voicePitch[1], 7'h33);
    intervals[4] = 7'h21;
    intervals[5] = 7'h50;
    SRC.send_pitch(7'h05);
    chkPitch(voicePitch[4], 7'h00);
    chkPitch(voicePitch[5], 7'h4a);
    SRC.send_pitch(7'h7e);
    chkPitch(voicePitch[3], 7'h7f);
    chkPitch(voicePitch[4], 7'h72);
    chkPitch(voicePitch[5], 7'h7f);
    $display("test harmonizer done");
    tuningStep = 8'h00;
    step2();
    chkVal(refFreqTenths, 13'h10cc);
    tuningStep = 8'hc8;
    step2();
    chkVal(refFreqTenths, 13'h1194);
    tuningStep = 8'hff;
    step2();
    chkVal(refFreqTenths, 13'h1194);
    masterResonance = 7'h32;
    masterCut = 7'h32;
    fbAmount = {8'h03, 8'h80, 8'h7f, 8'hff, 8'h64, 8'h9c};
    cutAmount = {8'h80, 8'h02, 8'h64, 8'hc9, 8'h01, 8'hff};
    step2();
    chkBytes(feedbackScaled, {8'h01, 8'hc0, 8'h3f, 8'h00, 8'h32, 8'hce});
    chkBytes(cutoffScaled, {8'h40, 8'h01, 8'h32, 8'h64, 8'h00, 8'h7f});
    masterResonance = 7'h00;
    masterCut = 7'h7f;
    step2();
    chkBytes(feedbackScaled, '0);
    chkBytes(cutoffScaled, {8'h80, 8'h02, 8'h64, 8'hc9, 8'h01, 8'hff});
    $display("test master scaling done");
    finish_test();
  end

  initial begin
    #200000;
    badCount++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
endmodule : tb_top
